// File: rtl/spi_cmd_pkg.sv
// constants and carrier types for the serial command decoder
package spi_cmd_pkg;

  // instruction bytes
  localparam logic [7:0] OP_RESET = 8'hC0;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_BIT_MODIFY = 8'h05;
  localparam logic [7:0] OP_READ_STATUS = 8'hA0;
  localparam logic [7:0] OP_RX_STATUS = 8'hB0;
  // upper five bits of the shortcut families
  localparam logic [4:0] OP_READ_RX_HI = 5'h12;
  localparam logic [4:0] OP_LOAD_TX_HI = 5'h08;
  localparam logic [4:0] OP_RTS_HI = 5'h10;
  localparam logic [2:0] LOAD_TX_LAST_CODE = 3'h5;

  // receive buffer shortcut targets: identifier start and data start
  localparam logic [7:0] RX0_ID_ADDR = 8'h61;
  localparam logic [7:0] RX0_DATA_ADDR = 8'h66;
  localparam logic [7:0] RX1_ID_ADDR = 8'h71;
  localparam logic [7:0] RX1_DATA_ADDR = 8'h76;
  // transmit buffer shortcut targets
  localparam logic [7:0] TX0_ID_ADDR = 8'h31;
  localparam logic [7:0] TX0_DATA_ADDR = 8'h36;
  localparam logic [7:0] TX1_ID_ADDR = 8'h41;
  localparam logic [7:0] TX1_DATA_ADDR = 8'h46;
  localparam logic [7:0] TX2_ID_ADDR = 8'h51;
  localparam logic [7:0] TX2_DATA_ADDR = 8'h56;

  // registers that accept a masked modify
  localparam logic [7:0] PIN_CTRL_ADDR = 8'h0C;
  localparam logic [7:0] RTS_PIN_CTRL_ADDR = 8'h0D;
  localparam logic [3:0] MODE_CTRL_LOW_NIBBLE = 4'hF;
  localparam logic [7:0] BITMOD_RANGE_LO = 8'h28;
  localparam logic [7:0] BITMOD_RANGE_HI = 8'h2D;
  localparam logic [7:0] TX0_CTRL_ADDR = 8'h30;
  localparam logic [7:0] TX1_CTRL_ADDR = 8'h40;
  localparam logic [7:0] TX2_CTRL_ADDR = 8'h50;
  localparam logic [7:0] RX0_CTRL_ADDR = 8'h60;
  localparam logic [7:0] RX1_CTRL_ADDR = 8'h70;
  localparam logic [7:0] FULL_MASK = 8'hFF;

  // synchroniser layout and reset values: {select_n, serial clock, serial in}
  localparam int PIN_CS = 2;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 0;
  localparam logic [2:0] PIN_SYNC_RESET = 3'h4;
  localparam logic [2:0] BIT_COUNT_LAST = 3'h7;

  localparam int WRITE_FIFO_DEPTH = 32;

  // per receive buffer details of the stored frame
  typedef struct packed {
    logic extended;
    logic remote;
    logic [2:0] filter_code;
  } rx_frame_info_type;

  // one register store handed to the register file
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] mask;
    logic [7:0] data;
  } reg_write_type;

  localparam int REG_WRITE_WIDTH = $bits(reg_write_type);

endpackage : spi_cmd_pkg

// File: rtl/spi_write_fifo.sv
// first-in first-out buffer for register stores
`timescale 1ns/1ps
`default_nettype none
module spi_write_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= next_count != FULL_COUNT;
      out_valid <= next_count != '0;
    end
  end
endmodule : spi_write_fifo
`default_nettype wire

// File: rtl/spi_command_decoder.sv
// serial instruction decoder for the controller's register and buffer access
`timescale 1ns/1ps
`default_nettype none
module spi_command_decoder
  import spi_cmd_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] rx_buffer_full_flag,
  input wire logic [2:0] tx_request_flag,
  input wire logic [2:0] tx_done_flag,
  input wire rx_frame_info_type rx_info_0,
  input wire rx_frame_info_type rx_info_1,
  output logic [2:0] tx_request_set,
  output logic [1:0] rx_flag_clear,
  output logic soft_reset,
  output logic write_ready,
  output logic write_valid,
  output reg_write_type write_entry,
  input wire logic write_accept
);

  typedef enum {
    ST_INSTR,
    ST_ADDR,
    ST_READ,
    ST_WRITE,
    ST_MASK,
    ST_MDATA,
    ST_STATUS,
    ST_RX_STATUS,
    ST_IGNORE
  } cmd_state_type;

  // shaded registers accepting a masked modify
  function automatic logic bit_modifiable(input logic [7:0] addr);
    bit_modifiable = (addr == PIN_CTRL_ADDR) || (addr == RTS_PIN_CTRL_ADDR)
      || (addr[3:0] == MODE_CTRL_LOW_NIBBLE)
      || (addr >= BITMOD_RANGE_LO && addr <= BITMOD_RANGE_HI)
      || (addr == TX0_CTRL_ADDR) || (addr == TX1_CTRL_ADDR) || (addr == TX2_CTRL_ADDR)
      || (addr == RX0_CTRL_ADDR) || (addr == RX1_CTRL_ADDR);
  endfunction : bit_modifiable

  // states in which serial out carries data
  function automatic logic drives_output(input cmd_state_type st);
    drives_output = (st == ST_READ) || (st == ST_STATUS) || (st == ST_RX_STATUS);
  endfunction : drives_output

  function automatic logic [7:0] tx_load_target(input logic [2:0] code);
    case (code)
      3'h0: tx_load_target = TX0_ID_ADDR;
      3'h1: tx_load_target = TX0_DATA_ADDR;
      3'h2: tx_load_target = TX1_ID_ADDR;
      3'h3: tx_load_target = TX1_DATA_ADDR;
      3'h4: tx_load_target = TX2_ID_ADDR;
      default: tx_load_target = TX2_DATA_ADDR;
    endcase
  endfunction : tx_load_target

  // pin synchronisers
  logic [2:0] pins;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic cs_d;
  logic sck_d;

  assign pins = {cs_n, sck, si};

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1 <= PIN_SYNC_RESET;
      sync2 <= PIN_SYNC_RESET;
      cs_d <= PIN_SYNC_RESET[PIN_CS];
      sck_d <= PIN_SYNC_RESET[PIN_SCK];
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      cs_d <= sync2[PIN_CS];
      sck_d <= sync2[PIN_SCK];
    end
  end

  logic selected;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  assign selected = ~sync2[PIN_CS];
  assign sck_rise = selected & sync2[PIN_SCK] & ~sck_d;
  assign sck_fall = selected & ~sync2[PIN_SCK] & sck_d;
  assign cs_rise = sync2[PIN_CS] & ~cs_d;

  // byte assembly, msb first
  logic [6:0] rx_shift;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic [7:0] byte_val;

  assign byte_done = sck_rise && (bit_cnt == BIT_COUNT_LAST);
  assign byte_val = {rx_shift, sync2[PIN_SI]};

  always_ff @(posedge mclk) begin
    if (srst || !selected) begin
      rx_shift <= '0;
      bit_cnt <= '0;
    end else if (sck_rise) begin
      rx_shift <= byte_val[6:0];
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // command sequencing
  cmd_state_type state;
  logic is_read;
  logic is_modify;
  logic [7:0] mask;

  always_ff @(posedge mclk) begin
    if (srst || !selected) begin
      state <= ST_INSTR;
      is_read <= 1'b0;
      is_modify <= 1'b0;
      mask <= FULL_MASK;
    end else if (byte_done) begin
      case (state)
        ST_INSTR: begin
          if (byte_val == OP_READ) begin
            is_read <= 1'b1;
            state <= ST_ADDR;
          end else if (byte_val == OP_WRITE) begin
            state <= ST_ADDR;
          end else if (byte_val == OP_BIT_MODIFY) begin
            is_modify <= 1'b1;
            state <= ST_ADDR;
          end else if (byte_val[7:3] == OP_READ_RX_HI && !byte_val[0]) begin
            state <= ST_READ;
          end else if (byte_val[7:3] == OP_LOAD_TX_HI && byte_val[2:0] <= LOAD_TX_LAST_CODE) begin
            state <= ST_WRITE;
          end else if (byte_val == OP_READ_STATUS) begin
            state <= ST_STATUS;
          end else if (byte_val == OP_RX_STATUS) begin
            state <= ST_RX_STATUS;
          end else begin
            state <= ST_IGNORE;
          end
        end
        ST_ADDR: begin
          if (is_modify) begin
            state <= ST_MASK;
          end else if (is_read) begin
            state <= ST_READ;
          end else begin
            state <= ST_WRITE;
          end
        end
        ST_MASK: begin
          mask <= byte_val;
          state <= ST_MDATA;
        end
        ST_MDATA: begin
          state <= ST_IGNORE;
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // address pointer, shown to the register file
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_addr <= '0;
    end else if (selected && byte_done) begin
      case (state)
        ST_INSTR: begin
          if (byte_val[7:3] == OP_READ_RX_HI && !byte_val[0]) begin
            case (byte_val[2:1])
              2'h0: rd_addr <= RX0_ID_ADDR;
              2'h1: rd_addr <= RX0_DATA_ADDR;
              2'h2: rd_addr <= RX1_ID_ADDR;
              default: rd_addr <= RX1_DATA_ADDR;
            endcase
          end else if (byte_val[7:3] == OP_LOAD_TX_HI && byte_val[2:0] <= LOAD_TX_LAST_CODE) begin
            rd_addr <= tx_load_target(byte_val[2:0]);
          end
        end
        ST_ADDR: begin
          rd_addr <= byte_val;
        end
        ST_READ, ST_WRITE: begin
          rd_addr <= rd_addr + 1'b1;
        end
        default: begin
          rd_addr <= rd_addr;
        end
      endcase
    end
  end

  // one-cycle command pulses
  logic rx_clear_armed;
  logic rx_clear_buf;

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_request_set <= '0;
      soft_reset <= 1'b0;
    end else begin
      tx_request_set <= '0;
      soft_reset <= 1'b0;
      if (byte_done && state == ST_INSTR) begin
        if (byte_val[7:3] == OP_RTS_HI) begin
          tx_request_set <= byte_val[2:0];
        end
        soft_reset <= byte_val == OP_RESET;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_clear_armed <= 1'b0;
      rx_clear_buf <= 1'b0;
      rx_flag_clear <= '0;
    end else begin
      rx_flag_clear <= '0;
      if (cs_rise) begin
        rx_clear_armed <= 1'b0;
        if (rx_clear_armed) begin
          rx_flag_clear <= rx_clear_buf ? 2'h2 : 2'h1;
        end
      end else if (byte_done && state == ST_INSTR && byte_val[7:3] == OP_READ_RX_HI && !byte_val[0]) begin
        rx_clear_armed <= 1'b1;
        rx_clear_buf <= byte_val[2];
      end
    end
  end

  // status bytes
  logic [7:0] status_byte;
  logic [7:0] rx_status_byte;
  rx_frame_info_type rx_info_sel;

  always_comb begin
    status_byte = {tx_done_flag[2], tx_request_flag[2], tx_done_flag[1], tx_request_flag[1],
                   tx_done_flag[0], tx_request_flag[0], rx_buffer_full_flag};
    if (rx_buffer_full_flag[0]) begin
      rx_info_sel = rx_info_0;
    end else if (rx_buffer_full_flag[1]) begin
      rx_info_sel = rx_info_1;
    end else begin
      rx_info_sel = '0;
    end
    rx_status_byte = {rx_buffer_full_flag[1], rx_buffer_full_flag[0], 1'b0,
                      rx_info_sel.extended, rx_info_sel.remote,
                      rx_info_sel.filter_code};
  end

  // serial out: load at the falling edge after a byte boundary, else shift
  logic at_boundary;
  logic out_started;
  logic [6:0] tx_shift;
  logic [7:0] rx_status_hold;
  logic [7:0] load_byte;

  always_comb begin
    case (state)
      ST_STATUS: load_byte = status_byte;
      ST_RX_STATUS: load_byte = out_started ? rx_status_hold : rx_status_byte;
      default: load_byte = rd_data;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst || !selected) begin
      at_boundary <= 1'b0;
      out_started <= 1'b0;
      tx_shift <= '0;
      rx_status_hold <= '0;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      if (byte_done) begin
        at_boundary <= 1'b1;
      end else if (sck_fall) begin
        at_boundary <= 1'b0;
      end
      if (sck_fall && drives_output(state)) begin
        if (at_boundary) begin
          so <= load_byte[7];
          tx_shift <= load_byte[6:0];
          out_started <= 1'b1;
          so_oe <= 1'b1;
          if (!out_started) begin
            rx_status_hold <= rx_status_byte;
          end
        end else begin
          so <= tx_shift[6];
          tx_shift <= {tx_shift[5:0], 1'b0};
        end
      end
    end
  end

  // register stores, in order, through the buffer
  logic push;
  reg_write_type push_entry;
  logic [REG_WRITE_WIDTH-1:0] fifo_out;

  assign push = byte_done && (state == ST_WRITE || state == ST_MDATA);
  assign push_entry.addr = rd_addr;
  assign push_entry.data = byte_val;
  assign push_entry.mask = (state == ST_MDATA && bit_modifiable(rd_addr)) ? mask : FULL_MASK;
  assign write_entry = reg_write_type'(fifo_out);

  spi_write_fifo #(
    .WIDTH(REG_WRITE_WIDTH),
    .DEPTH(WRITE_FIFO_DEPTH)
  ) write_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(push),
    .in_data(push_entry),
    .in_ready(write_ready),
    .out_valid(write_valid),
    .out_data(fifo_out),
    .out_ready(write_accept)
  );

endmodule : spi_command_decoder
`default_nettype wire

// File: tb/spi_host_model.sv
// serial master model driving the decoder's link pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  localparam realtime HALF = 62.5;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // each command opens with a fresh select
  task automatic sel();
    #50 cs_n = 1'b0;
    #HALF;
  endtask : sel
  // clock parked low, data line flipped once released
  task automatic desel();
    #100 cs_n = 1'b1;
    si = ~si;
    #100;
  endtask : desel
  // mode 0, msb first; fewer than eight bits leaves a partial byte
  task automatic xfer(input logic [7:0] tx, input int bits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - bits; i--) begin
      si = tx[i];
      #HALF sck = 1'b1;
      rx[i] = so;
      #HALF sck = 1'b0;
    end
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: tb/spi_command_decoder_assertions.sv
// port checks for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module spi_command_decoder_assertions
  import spi_cmd_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [2:0] tx_request_set,
  input wire logic [1:0] rx_flag_clear,
  input wire logic soft_reset,
  input wire logic write_ready,
  input wire logic write_valid,
  input wire reg_write_type write_entry,
  input wire logic write_accept
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_idle;
    cs_n [*4];
  endsequence
  sequence s_clock_high;
    (!cs_n && sck) [*6];
  endsequence
  AST_OE_IDLE: assert property (s_idle |-> !so_oe)
    else $error("so_oe high while deselected");
  AST_SO_HOLD: assert property (s_clock_high |-> $stable(so))
    else $error("so moved while clock high");
  AST_RTS_PULSE: assert property (|tx_request_set |=> tx_request_set == 3'h0)
    else $error("request pulse too long");
  AST_PULSE_IN_FRAME: assert property ((soft_reset || |tx_request_set) |-> !cs_n && !$past(cs_n, 8))
    else $error("command pulse outside a frame");
  AST_CLR_AFTER_RISE: assert property (|rx_flag_clear |-> cs_n && $past(cs_n, 2))
    else $error("flag clear before deselect");
  AST_CLR_ONEHOT: assert property ($onehot0(rx_flag_clear))
    else $error("two flags cleared");
  AST_FULL_VALID: assert property (!write_ready && !$past(srst) |-> write_valid)
    else $error("full without entries");
  AST_HEAD_HOLDS: assert property (write_valid && !write_accept |=> write_valid && $stable(write_entry))
    else $error("head entry lost");
endmodule : spi_command_decoder_assertions
`default_nettype wire

// File: tb/tb_spi_command_decoder.sv
// self-checking bench for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_spi_command_decoder import spi_cmd_pkg::*;;
  logic mclk, srst, cs_n, sck, si, so, so_oe, soft_reset, write_ready, write_valid, write_accept, rst_seen;
  logic [7:0] rd_addr, rd_data;
  logic [1:0] rxf, rx_flag_clear, clr_seen;
  logic [2:0] txr, txd, tx_request_set, rts_seen;
  rx_frame_info_type info0, info1;
  reg_write_type write_entry;
  logic [7:0] regs [256];
  logic [7:0] rxq [$];
  logic [7:0] q [$];
  localparam logic [7:0] rx_at [4] = '{RX0_ID_ADDR, RX0_DATA_ADDR, RX1_ID_ADDR, RX1_DATA_ADDR};
  localparam logic [7:0] tx_at [6] = '{TX0_ID_ADDR, TX0_DATA_ADDR, TX1_ID_ADDR, TX1_DATA_ADDR, TX2_ID_ADDR,
    TX2_DATA_ADDR};
  int error_cnt = 0;
  int checks_done = 0;
  int pops = 0;
  int p0;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  logic so_line;
  // undriven line reads inverted, so a late enable corrupts data
  assign so_line = so_oe ? so : ~so;
  spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
  spi_command_decoder dut (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
    .rd_addr(rd_addr), .rd_data(rd_data), .rx_buffer_full_flag(rxf), .tx_request_flag(txr), .tx_done_flag(txd),
    .rx_info_0(info0), .rx_info_1(info1), .tx_request_set(tx_request_set), .rx_flag_clear(rx_flag_clear),
    .soft_reset(soft_reset), .write_ready(write_ready), .write_valid(write_valid), .write_entry(write_entry),
    .write_accept(write_accept));
  assign rd_data = regs[rd_addr];
  // register file: masked store per pop, pulses gathered
  always @(posedge mclk) begin
    if (write_valid && write_accept) begin
      regs[write_entry.addr] <= (regs[write_entry.addr] & ~write_entry.mask) | (write_entry.data & write_entry.mask);
      pops <= pops + 1;
    end
    // outputs are unknown before the first reset edge
    if (!srst) begin
      rts_seen <= rts_seen | tx_request_set;
      clr_seen <= clr_seen | rx_flag_clear;
      rst_seen <= rst_seen | soft_reset;
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic cmd(input logic [7:0] b[$], input int reads, input int part);
    logic [7:0] r;
    rxq.delete();
    host.sel();
    foreach (b[i])
      host.xfer(b[i], 8, r);
    repeat (reads) begin
      host.xfer(8'h00, 8, r);
      rxq.push_back(r);
    end
    if (part > 0)
      host.xfer(8'hFF, part, r);
    host.desel();
    @(posedge mclk);
    #1;
  endtask : cmd
  task automatic drain();
    int k;
    k = 0;
    while (write_valid !== 1'b0 && k < 300) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k == 300) begin
      error_cnt++;
      summarize();
    end
  endtask : drain
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  initial begin
    srst = 1'b1;
    write_accept = 1'b1;
    rxf = 2'h0;
    txr = 3'h0;
    txd = 3'h0;
    info0 = 5'h00;
    info1 = 5'h00;
    rts_seen = 3'h0;
    clr_seen = 2'h0;
    rst_seen = 1'b0;
    for (int i = 0; i < 256; i++)
      regs[i] = 8'(i);
    repeat (12) @(posedge mclk);
    #1 srst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    cmd('{OP_WRITE, 8'h10, 8'hAA, 8'hBB}, 0, 4);
    drain();
    check("wr_10", regs[8'h10], 8'hAA);
    check("wr_11", regs[8'h11], 8'hBB);
    check("wr_12", regs[8'h12], 8'h12);
    cmd('{OP_READ, 8'h10}, 3, 0);
    check("rd_10", rxq[0], 8'hAA);
    check("rd_11", rxq[1], 8'hBB);
    check("rd_12", rxq[2], 8'h12);
    check("so_oe", {7'h0, so_oe}, 8'h00);
    cmd('{OP_BIT_MODIFY, 8'h2C, 8'h0F, 8'hA5}, 0, 0);
    cmd('{OP_BIT_MODIFY, 8'h13, 8'h0F, 8'hA5}, 0, 0);
    drain();
    check("bm_2c", regs[8'h2C], 8'h25);
    check("bm_13", regs[8'h13], 8'hA5);
    $display("test write read modify done");
    for (int n = 0; n < 8; n++) begin
      rts_seen = 3'h0;
      cmd('{{OP_RTS_HI, 3'(n)}}, 0, 0);
      check("rts", 8'(rts_seen), 8'(n));
    end
    rxf = 2'h1;
    txr = 3'h5;
    txd = 3'h2;
    cmd('{OP_READ_STATUS}, 2, 0);
    check("stat0", rxq[0], 8'h65);
    check("stat1", rxq[1], 8'h65);
    rxf = 2'h3;
    info0 = 5'h14;
    info1 = 5'h0E;
    fork
      cmd('{OP_RX_STATUS}, 2, 0);
      // details change once the first byte is latched
      #1500 info0 = 5'h00;
    join
    check("rxs0", rxq[0], 8'hD4);
    check("rxs1", rxq[1], 8'hD4);
    rxf = 2'h2;
    cmd('{OP_RX_STATUS}, 1, 0);
    check("rxs_b1", rxq[0], 8'h8E);
    $display("test status done");
    for (int n = 0; n < 4; n++) begin
      clr_seen = 2'h0;
      cmd('{{OP_READ_RX_HI, 2'(n), 1'b0}}, 2, 0);
      check("rxb", rxq[0], rx_at[n]);
      check("rxb_inc", rxq[1], rx_at[n] + 8'h01);
      check("rxclr", 8'(clr_seen), n[1] ? 8'h02 : 8'h01);
    end
    for (int c = 0; c < 6; c++) begin
      cmd('{{OP_LOAD_TX_HI, 3'(c)}, 8'hC0 + 8'(c)}, 0, 0);
      drain();
      check("ldtx", regs[tx_at[c]], 8'hC0 + 8'(c));
    end
    p0 = pops;
    cmd('{{OP_LOAD_TX_HI, 3'h6}, 8'h77}, 0, 0);
    cmd('{8'hFF, 8'h10, 8'h77}, 0, 0);
    drain();
    check("refused", 8'(pops - p0), 8'h00);
    cmd('{OP_RESET}, 0, 0);
    check("soft_rst", {7'h0, rst_seen}, 8'h01);
    $display("test shortcuts done");
    write_accept = 1'b0;
    q = '{OP_WRITE, 8'h80};
    for (int i = 0; i < 33; i++)
      q.push_back(8'h40 + 8'(i));
    cmd(q, 0, 0);
    check("full", {7'h0, write_ready}, 8'h00);
    write_accept = 1'b1;
    drain();
    check("fifo_last", regs[8'h9F], 8'h5F);
    check("fifo_drop", regs[8'hA0], 8'hA0);
    $display("test buffer done");
    summarize();
  end
endmodule : tb_spi_command_decoder
bind spi_command_decoder spi_command_decoder_assertions chk (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sck(sck),
  .so(so), .so_oe(so_oe), .tx_request_set(tx_request_set), .rx_flag_clear(rx_flag_clear), .soft_reset(soft_reset),
  .write_ready(write_ready), .write_valid(write_valid), .write_entry(write_entry), .write_accept(write_accept));
`default_nettype wire
